//--- csw_defs.vh
// constants for the clock source switch and fail monitor
`ifndef CSW_DEFS_VH
`define CSW_DEFS_VH

// ****************************************
// oscillator group codes
// ****************************************
`define CSW_GRP_SECONDARY   3'h0
`define CSW_GRP_FAST_RC     3'h1
`define CSW_GRP_SLOW_RC     3'h2
`define CSW_GRP_PRIMARY     3'h3
`define CSW_GRP_MULTIPLIED  3'h7

// ****************************************
// switch and monitor configuration
// ****************************************
`define CSW_CFG_DISABLE_BIT 1
`define CSW_CFG_SW_MON      2'h0
`define CSW_CFG_SW_ONLY     2'h1

// ****************************************
// primary choice fields
// ****************************************
`define CSW_GAIN_LSB        0
`define CSW_GAIN_MSB        1
`define CSW_GAIN_NONE       2'h0
`define CSW_GAIN_X4         2'h1
`define CSW_GAIN_X8         2'h2
`define CSW_GAIN_X16        2'h3
`define CSW_SRC_LSB         2
`define CSW_SRC_MSB         4
`define CSW_SRC_FAST_RC     3'h1

// ****************************************
// trim
// ****************************************
`define CSW_TRIM_RESET      4'h0
`define CSW_TRIM_SIGN_BIT   3
// one trim code step in tenths of a percent (1.5 %)
`define CSW_TRIM_STEP       8'h0f

// ****************************************
// monitor
// ****************************************
`define CSW_MON_WINDOW      4'h4

`endif

//--- csw_edge_monitor.v
// fail-safe monitor: oscillator edge watchdog timed by the slow rc clock
`timescale 1ns/1ps
`default_nettype none
`include "csw_defs.vh"

module csw_edge_monitor #(
  parameter CNT_W        = 4,
  parameter [3:0] WINDOW = `CSW_MON_WINDOW
) (
  // clock and reset
  input  wire i_clk,
  input  wire i_rst_n,
  // control
  input  wire i_enable,
  // synchronised levels
  input  wire i_osc_level,
  input  wire i_tick_level,
  // result
  output reg  o_fail
);

  // ****************************************
  // edge detection on synchronised levels
  // ****************************************
  reg             osc_prev;
  reg             tick_prev;
  reg [CNT_W-1:0] ticks;
  wire            osc_edge;
  wire            tick_edge;

  assign osc_edge  = i_osc_level != osc_prev;
  assign tick_edge = i_tick_level & ~tick_prev;

  // ****************************************
  // window count
  // ****************************************
  // any oscillator edge restarts the window; a window full of slow ticks
  // without one is a failure
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      osc_prev  <= 1'b0;
      tick_prev <= 1'b0;
      ticks     <= {CNT_W{1'b0}};
      o_fail    <= 1'b0;
    end else begin
      osc_prev  <= i_osc_level;
      tick_prev <= i_tick_level;
      o_fail    <= 1'b0;
      if (!i_enable || osc_edge) begin
        ticks <= {CNT_W{1'b0}};
      end else if (tick_edge) begin
        if (ticks == WINDOW[CNT_W-1:0] - 1'b1) begin
          ticks  <= {CNT_W{1'b0}};
          o_fail <= 1'b1;
        end else begin
          ticks <= ticks + 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

//--- csw_clock_ctrl.v
// clock source switch, multiplier control, rc trim and fail-safe monitor
`timescale 1ns/1ps
`default_nettype none
`include "csw_defs.vh"
module csw_clock_ctrl #(
  parameter SYNC_N = 5
) (
  // clock and reset
  input  wire       i_clk,
  input  wire       i_rst_n,
  // configuration bits
  input  wire [2:0] i_reset_group_cfg,
  input  wire [4:0] i_primary_choice_cfg,
  input  wire [1:0] i_switch_monitor_cfg,
  input  wire       i_watchdog_cfg_enable,
  // software control
  input  wire       i_requested_group_wr,
  input  wire [2:0] i_requested_group_data,
  input  wire       i_switch_request_wr,
  input  wire       i_switch_request_data,
  input  wire       i_clock_fail_clr,
  input  wire       i_rc_trim_wr,
  input  wire [3:0] i_rc_trim_data,
  input  wire       i_soft_watchdog_enable,
  // power state
  input  wire       i_sleep,
  input  wire       i_wake,
  // asynchronous oscillator side inputs
  input  wire       i_pll_lock_raw,
  input  wire       i_osc_activity,
  input  wire       i_slow_rc_level,
  input  wire       i_powerup_timer_done,
  input  wire       i_new_osc_ready,
  // status and control outputs
  output reg  [2:0] o_current_group,
  output reg  [2:0] o_requested_group,
  output reg        o_switch_request,
  output reg        o_clock_fail_flag,
  output reg        o_clock_fail_trap,
  output reg        o_lock_status,
  output reg  [3:0] o_rc_trim,
  output reg  [7:0] o_rc_trim_offset,
  output reg  [1:0] o_pll_gain,
  output reg        o_pll_enable,
  output reg        o_pll_src_fast_rc,
  output reg        o_fast_rc_enable,
  output reg        o_slow_rc_enable,
  output reg  [2:0] o_new_group_start,
  output reg        o_new_group_start_en,
  output reg        o_switch_busy
);

  // ****************************************
  // input synchronisers
  // ****************************************
  wire [SYNC_N-1:0] async_in;
  wire [SYNC_N-1:0] sync_out;

  assign async_in = {i_new_osc_ready, i_powerup_timer_done, i_slow_rc_level,
                     i_osc_activity, i_pll_lock_raw};

  genvar g;
  generate
    for (g = 0; g < SYNC_N; g = g + 1) begin : g_sync
      reg ff1;
      reg ff2;
      always @(posedge i_clk) begin
        if (!i_rst_n) begin
          ff1 <= 1'b0;
          ff2 <= 1'b0;
        end else begin
          ff1 <= async_in[g];
          ff2 <= ff1;
        end
      end
      assign sync_out[g] = ff2;
    end
  endgenerate

  wire pll_lock;
  wire osc_level;
  wire tick_level;
  wire powerup_timer_done;
  wire new_ready;

  assign pll_lock   = sync_out[0];
  assign osc_level  = sync_out[1];
  assign tick_level = sync_out[2];
  assign powerup_timer_done  = sync_out[3];
  assign new_ready  = sync_out[4];

  // ****************************************
  // configuration decode
  // ****************************************
  wire switch_en;
  wire monitor_en;
  wire req_rise;
  wire req_fall;
  reg  powerup_timer_prev;
  reg  start_pending;
  wire powerup_timer_rise;
  wire mon_fail;
  wire late_start;
  wire fail_event;
  wire redundant;

  assign switch_en  = ~i_switch_monitor_cfg[`CSW_CFG_DISABLE_BIT];
  assign monitor_en = (i_switch_monitor_cfg == `CSW_CFG_SW_MON);
  assign req_rise   = i_switch_request_wr & i_switch_request_data &
                      ~o_switch_request;
  assign req_fall   = i_switch_request_wr & ~i_switch_request_data;
  assign powerup_timer_rise  = powerup_timer_done & ~powerup_timer_prev;
  assign late_start = monitor_en & powerup_timer_rise & start_pending;
  assign fail_event = monitor_en & ~i_sleep & (mon_fail | late_start);
  assign redundant  = (o_requested_group == o_current_group);

  // ****************************************
  // fail-safe monitor
  // ****************************************
  csw_edge_monitor #(
    .CNT_W  (4),
    .WINDOW (`CSW_MON_WINDOW)
  ) u_monitor (
    .i_clk        (i_clk),
    .i_rst_n      (i_rst_n),
    .i_enable     (monitor_en & ~i_sleep & ~start_pending),
    .i_osc_level  (osc_level),
    .i_tick_level (tick_level),
    .o_fail       (mon_fail)
  );

  // ****************************************
  // start-up tracking after reset or wake
  // ****************************************
  // the selected oscillator counts as started once the ready input is high;
  // if the powerup timer rises first or in the same cycle, the monitor calls it a failure
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      powerup_timer_prev     <= 1'b0;
      start_pending <= 1'b1;
    end else begin
      powerup_timer_prev <= powerup_timer_done;
      if (i_wake) begin
        start_pending <= 1'b1;
      end else if (new_ready || powerup_timer_rise) begin
        start_pending <= 1'b0;
      end
    end
  end

  // ****************************************
  // switch sequencer
  // ****************************************
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_START = 2'h1;
  localparam [1:0] ST_DONE  = 2'h2;

  reg [1:0] state;
  reg [1:0] next_state;
  reg       cfg_loaded;

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (switch_en && req_rise && !fail_event) begin
          next_state = ST_START;
        end
      end
      ST_START: begin
        if (fail_event || req_fall) begin
          next_state = ST_IDLE;
        end else if (redundant || new_ready) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // group fields, request and fail flag
  // ****************************************
  // reset cannot sample the configuration pins, so the first clocked
  // cycle after release loads both group fields from them
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      cfg_loaded        <= 1'b0;
      o_current_group   <= `CSW_GRP_SECONDARY;
      o_requested_group <= `CSW_GRP_SECONDARY;
      o_switch_request  <= 1'b0;
      o_clock_fail_flag <= 1'b0;
      o_clock_fail_trap <= 1'b0;
    end else begin
      o_clock_fail_trap <= 1'b0;
      if (!cfg_loaded) begin
        cfg_loaded        <= 1'b1;
        o_current_group   <= i_reset_group_cfg;
        o_requested_group <= i_reset_group_cfg;
      end else if (fail_event) begin
        o_current_group   <= `CSW_GRP_FAST_RC;
        o_switch_request  <= 1'b0;
        o_clock_fail_flag <= 1'b1;
        o_clock_fail_trap <= 1'b1;
      end else begin
        if (!switch_en) begin
          o_current_group <= i_reset_group_cfg;
        end else if (state == ST_DONE) begin
          o_current_group  <= o_requested_group;
          o_switch_request <= 1'b0;
        end
        if (i_requested_group_wr) begin
          o_requested_group <= i_requested_group_data;
        end
        if (i_switch_request_wr && state != ST_DONE) begin
          o_switch_request <= i_switch_request_data & switch_en;
        end
        if (req_rise && switch_en) begin
          o_clock_fail_flag <= 1'b0;
        end else if (i_clock_fail_clr) begin
          o_clock_fail_flag <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // multiplier control and lock status
  // ****************************************
  wire [1:0] gain_sel;
  wire       pll_sel;

  assign gain_sel = i_primary_choice_cfg[`CSW_GAIN_MSB:`CSW_GAIN_LSB];
  assign pll_sel  = (o_current_group == `CSW_GRP_MULTIPLIED);

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pll_gain        <= `CSW_GAIN_NONE;
      o_pll_enable      <= 1'b0;
      o_pll_src_fast_rc <= 1'b0;
      o_lock_status     <= 1'b0;
    end else begin
      o_pll_gain        <= gain_sel;
      o_pll_enable      <= pll_sel && gain_sel != `CSW_GAIN_NONE;
      o_pll_src_fast_rc <= pll_sel && i_primary_choice_cfg[`CSW_SRC_MSB:`CSW_SRC_LSB]
                           == `CSW_SRC_FAST_RC;
      // lock reads zero when the multiplier is not the system clock
      if (req_rise && switch_en) begin
        o_lock_status <= 1'b0;
      end else begin
        o_lock_status <= pll_lock & o_pll_enable;
      end
    end
  end

  // ****************************************
  // fast rc trim
  // ****************************************
  // the limit on trimming with x16 is left to software; hardware applies
  // whatever code is written
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rc_trim        <= `CSW_TRIM_RESET;
      o_rc_trim_offset <= 8'h00;
    end else begin
      if (i_rc_trim_wr) begin
        o_rc_trim <= i_rc_trim_data;
      end
      o_rc_trim_offset <= {{4{o_rc_trim[`CSW_TRIM_SIGN_BIT]}}, o_rc_trim} *
                          `CSW_TRIM_STEP;
    end
  end

  // ****************************************
  // oscillator enables
  // ****************************************
  wire grp_fast;
  wire grp_slow;
  wire start_fast;
  wire start_slow;
  wire wdt_on;

  assign grp_fast   = (o_current_group == `CSW_GRP_FAST_RC) |
                      (o_pll_src_fast_rc & pll_sel);
  assign grp_slow   = (o_current_group == `CSW_GRP_SLOW_RC);
  assign start_fast = o_new_group_start_en &
                      (o_new_group_start == `CSW_GRP_FAST_RC);
  assign start_slow = o_new_group_start_en &
                      (o_new_group_start == `CSW_GRP_SLOW_RC);
  assign wdt_on     = i_watchdog_cfg_enable | i_soft_watchdog_enable;

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_fast_rc_enable <= 1'b0;
      o_slow_rc_enable <= 1'b1;
    end else begin
      o_fast_rc_enable <= grp_fast | start_fast | fail_event;
      if (!powerup_timer_done) begin
        o_slow_rc_enable <= 1'b1;
      end else begin
        o_slow_rc_enable <= (monitor_en & ~i_sleep) | wdt_on | grp_slow |
                            start_slow;
      end
    end
  end

  // ****************************************
  // new group start request
  // ****************************************
  // only whole groups are started; the choice inside the primary group
  // always comes from the configuration pins
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_new_group_start    <= `CSW_GRP_SECONDARY;
      o_new_group_start_en <= 1'b0;
      o_switch_busy        <= 1'b0;
    end else begin
      o_new_group_start    <= o_requested_group;
      o_new_group_start_en <= (next_state == ST_START);
      o_switch_busy        <= (next_state != ST_IDLE);
    end
  end

endmodule

`default_nettype wire

//--- csw_clock_ctrl_properties.sv
// concurrent checks on the ports of the clock source switch
`timescale 1ns/1ps
`default_nettype none
`include "csw_defs.vh"
module csw_clock_ctrl_properties (
  // clock and reset
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  // inputs watched
  input wire logic [2:0] i_reset_group_cfg,
  input wire logic [4:0] i_primary_choice_cfg,
  input wire logic [1:0] i_switch_monitor_cfg,
  input wire logic       i_pll_lock_raw,
  input wire logic       i_powerup_timer_done,
  // outputs watched
  input wire logic [2:0] o_current_group,
  input wire logic       o_switch_request,
  input wire logic       o_clock_fail_flag,
  input wire logic       o_clock_fail_trap,
  input wire logic       o_lock_status,
  input wire logic [3:0] o_rc_trim,
  input wire logic [7:0] o_rc_trim_offset,
  input wire logic [1:0] o_pll_gain,
  input wire logic       o_pll_enable,
  input wire logic       o_fast_rc_enable,
  input wire logic       o_slow_rc_enable,
  input wire logic       o_new_group_start_en,
  input wire logic       o_switch_busy
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ****************************************
  // switch start and end sequences
  // ****************************************
  sequence req_rise;
    $rose(o_switch_request);
  endsequence
  sequence busy_end;
    $fell(o_switch_busy);
  endsequence
  // ****************************************
  // assertions
  // ****************************************
  trap_one_cycle_a: assert property (o_clock_fail_trap |=> !o_clock_fail_trap)
    else $error("fail trap longer than one cycle");
  trap_effects_a: assert property (o_clock_fail_trap |->
    o_current_group == `CSW_GRP_FAST_RC && o_clock_fail_flag && !o_switch_request)
    else $error("failure did not load fast rc, set flag, clear request");
  flag_with_trap_a: assert property ($rose(o_clock_fail_flag) |-> o_clock_fail_trap)
    else $error("fail flag rose without a trap");
  disabled_request_a: assert property (i_switch_monitor_cfg[1] |-> !o_switch_request)
    else $error("switch request set while switching disabled");
  disabled_follow_a: assert property (
    ($past(i_rst_n) && i_switch_monitor_cfg[1] && $stable(i_reset_group_cfg)) [*2] |->
    o_current_group == i_reset_group_cfg)
    else $error("current group does not follow configuration");
  gain_follow_a: assert property ($past(i_rst_n) && $stable(i_primary_choice_cfg) |->
    o_pll_gain == i_primary_choice_cfg[1:0])
    else $error("multiplier gain differs from configuration");
  lock_source_a: assert property ($rose(o_lock_status) |-> $past(i_pll_lock_raw, 3))
    else $error("lock status rose without lock");
  lock_selected_a: assert property (o_lock_status |-> o_pll_enable || $past(o_pll_enable))
    else $error("lock status while multiplier not selected");
  start_effects_a: assert property (req_rise |->
    o_switch_busy && o_new_group_start_en && !o_clock_fail_flag)
    else $error("request rise did not start a switch");
  end_clears_a: assert property (busy_end |-> !o_switch_request)
    else $error("switch ended with request still set");
  trim_offset_a: assert property ($past(i_rst_n) |-> o_rc_trim_offset ==
    8'({{4{$past(o_rc_trim[3])}}, $past(o_rc_trim)} * `CSW_TRIM_STEP))
    else $error("trim offset wrong");
  slow_rc_boot_a: assert property ((!i_powerup_timer_done) [*4] |-> o_slow_rc_enable)
    else $error("slow rc off before powerup expiry");
  fast_rc_on_a: assert property (
    o_current_group == `CSW_GRP_FAST_RC && $past(o_current_group) == `CSW_GRP_FAST_RC
    |-> o_fast_rc_enable)
    else $error("fast rc off while selected");
endmodule
`default_nettype wire

//--- csw_clock_ctrl_bench.sv
// self-checking bench for the clock source switch and fail monitor
`timescale 1ns/1ps
`default_nettype none
`include "csw_defs.vh"
module csw_clock_ctrl_bench;
  logic i_clk = 1'b0;
  logic i_rst_n, i_watchdog_cfg_enable, i_sleep, i_wake, i_soft_watchdog_enable;
  logic i_requested_group_wr, i_switch_request_wr, i_switch_request_data;
  logic i_clock_fail_clr, i_rc_trim_wr, i_pll_lock_raw, i_osc_activity;
  logic i_slow_rc_level, i_powerup_timer_done, i_new_osc_ready, osc_run;
  logic [2:0] i_reset_group_cfg, i_requested_group_data;
  logic [4:0] i_primary_choice_cfg;
  logic [1:0] i_switch_monitor_cfg, slow_div;
  logic [3:0] i_rc_trim_data, c;
  logic [7:0] n_trap;
  wire  [2:0] o_current_group, o_requested_group, o_new_group_start;
  wire        o_switch_request, o_clock_fail_flag, o_clock_fail_trap, o_lock_status;
  wire        o_pll_enable, o_pll_src_fast_rc, o_fast_rc_enable, o_slow_rc_enable;
  wire        o_new_group_start_en, o_switch_busy;
  wire  [3:0] o_rc_trim;
  wire  [7:0] o_rc_trim_offset;
  wire  [1:0] o_pll_gain;
  int n_errors = 0;
  int n_compared = 0;
  logic [11:0] notes[$];
  logic [2:0] grp [6] = '{3'h7, 3'h3, 3'h0, 3'h1, 3'h2, 3'h7};
  event look;

  csw_clock_ctrl uut (.i_clk, .i_rst_n, .i_reset_group_cfg, .i_primary_choice_cfg,
    .i_switch_monitor_cfg, .i_watchdog_cfg_enable, .i_requested_group_wr,
    .i_requested_group_data, .i_switch_request_wr, .i_switch_request_data,
    .i_clock_fail_clr, .i_rc_trim_wr, .i_rc_trim_data, .i_soft_watchdog_enable,
    .i_sleep, .i_wake, .i_pll_lock_raw, .i_osc_activity, .i_slow_rc_level,
    .i_powerup_timer_done, .i_new_osc_ready, .o_current_group, .o_requested_group,
    .o_switch_request, .o_clock_fail_flag, .o_clock_fail_trap, .o_lock_status,
    .o_rc_trim, .o_rc_trim_offset, .o_pll_gain, .o_pll_enable, .o_pll_src_fast_rc,
    .o_fast_rc_enable, .o_slow_rc_enable, .o_new_group_start, .o_new_group_start_en,
    .o_switch_busy);

  always #5 i_clk = ~i_clk;
  // ****************************************
  // oscillator side: monitored clock activity and slow rc level
  // ****************************************
  always @(posedge i_clk) begin
    if (osc_run) i_osc_activity <= ~i_osc_activity;
    slow_div <= slow_div + 2'h1;
    i_slow_rc_level <= slow_div[1];
    if (o_clock_fail_trap === 1'b1) n_trap <= n_trap + 8'h1;
  end
  // ****************************************
  // result watcher
  // ****************************************
  function automatic logic [7:0] obs(input logic [3:0] s);
    case (s)
      4'h0: obs = {5'h0, o_current_group};
      4'h1: obs = {5'h0, o_requested_group};
      4'h2: obs = {4'h0, o_rc_trim};
      4'h3: obs = o_rc_trim_offset;
      4'h4: obs = {6'h0, o_pll_gain};
      4'h5: obs = n_trap;
      4'h6: obs = {7'h0, o_switch_request};
      4'h7: obs = {7'h0, o_switch_busy};
      4'h8: obs = {7'h0, o_clock_fail_flag};
      4'h9: obs = {7'h0, o_pll_enable};
      4'ha: obs = {7'h0, o_lock_status};
      4'hb: obs = {7'h0, o_slow_rc_enable};
      4'hc: obs = {7'h0, o_fast_rc_enable};
      4'hd: obs = {7'h0, o_new_group_start_en};
      4'he: obs = {7'h0, o_pll_src_fast_rc};
      default: obs = {5'h0, o_new_group_start};
    endcase
  endfunction
  task automatic cmp_field(input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_flag(input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  always @(look) begin : watch
    logic [11:0] n;
    logic [7:0] g;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      g = obs(n[11:8]);
      if (n[11:8] < 4'h6 || n[11:8] == 4'hf) cmp_field(n[7:0], g);
      else cmp_flag(n[0], g[0]);
    end
  end
  // ****************************************
  // driver tasks
  // ****************************************
  task automatic want(input logic [3:0] s, input logic [7:0] v);
    notes.push_back({s, v});
    ->look;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // k: 0 requested group, 1 switch request, 2 trim, 3 clear fail flag
  task automatic sw_write(input int k, input logic [3:0] d);
    @(posedge i_clk);
    i_requested_group_data <= d[2:0];
    i_switch_request_data <= d[0];
    i_rc_trim_data <= d;
    {i_requested_group_wr, i_switch_request_wr} <= {k == 0, k == 1};
    {i_rc_trim_wr, i_clock_fail_clr} <= {k == 2, k == 3};
    @(posedge i_clk);
    {i_requested_group_wr, i_switch_request_wr, i_rc_trim_wr, i_clock_fail_clr} <= 4'h0;
    #1;
  endtask
  // bounded waits: the switch wait on ready is unbounded in the design
  task automatic wait_idle;
    for (int w = 0; w < 50 && o_switch_busy !== 1'b0; w++) tick(1);
    if (o_switch_busy !== 1'b0) n_errors++;
    tick(2);
  endtask
  task automatic wait_trap(input logic [7:0] n);
    for (int w = 0; w < 400 && n_trap < n; w++) tick(1);
    if (n_trap < n) n_errors++;
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    test_done();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    void'($urandom(58));
    {i_rst_n, i_watchdog_cfg_enable, i_sleep, i_wake, i_soft_watchdog_enable} = 5'h0;
    {i_requested_group_wr, i_switch_request_wr, i_clock_fail_clr, i_rc_trim_wr} = 4'h0;
    {i_pll_lock_raw, i_osc_activity, i_powerup_timer_done, i_new_osc_ready} = 4'h0;
    {i_switch_request_data, i_requested_group_data, i_rc_trim_data} = 8'h0;
    {i_slow_rc_level, slow_div, n_trap, osc_run} = 12'h1;
    {i_reset_group_cfg, i_primary_choice_cfg, i_switch_monitor_cfg} = {3'h3, 5'h07, 2'h2};
    tick(16);
    want(4'hb, 8'h1);
    want(4'h6, 8'h0);
    @(posedge i_clk) i_rst_n <= 1'b1;
    tick(2);
    want(4'h0, 8'h3);
    want(4'h1, 8'h3);
    $display("test reset ended");
    @(posedge i_clk) i_powerup_timer_done <= 1'b1;
    sw_write(0, 4'h2);
    sw_write(1, 4'h1);
    tick(1);
    want(4'h6, 8'h0);
    want(4'h1, 8'h2);
    want(4'h0, 8'h3);
    @(posedge i_clk) i_reset_group_cfg <= 3'h7;
    tick(3);
    want(4'h0, 8'h7);
    want(4'he, 8'h1);
    want(4'hb, 8'h0);
    @(posedge i_clk) i_pll_lock_raw <= 1'b1;
    tick(5);
    want(4'ha, 8'h1);
    @(posedge i_clk) i_pll_lock_raw <= 1'b0;
    tick(5);
    want(4'ha, 8'h0);
    for (int g = 0; g < 4; g++) begin
      @(posedge i_clk) i_primary_choice_cfg <= {3'h1, 2'(g)};
      tick(3);
      want(4'h4, 8'(g));
      want(4'h9, {7'h0, g != 0});
    end
    $display("test disabled switching ended");
    // x16 must not run on a fast rc trimmed upward, so trim under x8
    @(posedge i_clk) i_primary_choice_cfg <= {3'h1, 2'h2};
    for (int i = 0; i < 10; i++) begin
      c = (i == 0) ? 4'h7 : (i == 1) ? 4'h8 : 4'($urandom);
      sw_write(2, c);
      want(4'h2, {4'h0, c});
      tick(1);
      want(4'h3, {{4{c[3]}}, c} * `CSW_TRIM_STEP);
    end
    $display("test trim ended");
    @(posedge i_clk) i_switch_monitor_cfg <= 2'h1;
    tick(2);
    foreach (grp[i]) begin
      sw_write(0, {1'b0, grp[i]});
      sw_write(1, 4'h1);
      want(4'h6, 8'h1);
      want(4'h7, 8'h1);
      want(4'hd, 8'h1);
      want(4'hf, {5'h0, grp[i]});
      @(posedge i_clk) i_new_osc_ready <= 1'b1;
      wait_idle();
      want(4'h0, {5'h0, grp[i]});
      want(4'h6, 8'h0);
      if (grp[i] == 3'h1) want(4'hc, 8'h1);
      want(4'hb, {7'h0, grp[i] == 3'h2});
      @(posedge i_clk) i_new_osc_ready <= 1'b0;
      tick(3);
    end
    sw_write(0, 4'h0);
    sw_write(1, 4'h1);
    tick(4);
    sw_write(1, 4'h0);
    tick(2);
    want(4'h7, 8'h0);
    want(4'h0, 8'h7);
    $display("test switching ended");
    @(posedge i_clk) {i_switch_monitor_cfg, i_watchdog_cfg_enable} <= 3'h1;
    sw_write(0, 4'h3);
    sw_write(1, 4'h1);
    @(posedge i_clk) osc_run <= 1'b0;
    wait_trap(8'h1);
    tick(1);
    want(4'h5, 8'h1);
    want(4'h0, 8'h1);
    want(4'h8, 8'h1);
    want(4'h6, 8'h0);
    want(4'hc, 8'h1);
    want(4'hb, 8'h1);
    @(posedge i_clk) osc_run <= 1'b1;
    sw_write(3, 4'h0);
    want(4'h8, 8'h0);
    @(posedge i_clk) {i_sleep, i_watchdog_cfg_enable} <= 2'h2;
    tick(2);
    want(4'hb, 8'h0);
    @(posedge i_clk) {i_sleep, i_watchdog_cfg_enable} <= 2'h1;
    @(posedge i_clk) i_powerup_timer_done <= 1'b0;
    tick(4);
    @(posedge i_clk) i_wake <= 1'b1;
    @(posedge i_clk) i_wake <= 1'b0;
    tick(4);
    @(posedge i_clk) i_powerup_timer_done <= 1'b1;
    wait_trap(8'h2);
    tick(1);
    want(4'h5, 8'h2);
    want(4'h8, 8'h1);
    want(4'h0, 8'h1);
    $display("test failure ended");
    tick(2);
    test_done();
  end
endmodule

bind csw_clock_ctrl csw_clock_ctrl_properties chk (.i_clk, .i_rst_n, .i_reset_group_cfg,
  .i_primary_choice_cfg, .i_switch_monitor_cfg, .i_pll_lock_raw, .i_powerup_timer_done,
  .o_current_group, .o_switch_request, .o_clock_fail_flag, .o_clock_fail_trap,
  .o_lock_status, .o_rc_trim, .o_rc_trim_offset, .o_pll_gain, .o_pll_enable,
  .o_fast_rc_enable, .o_slow_rc_enable, .o_new_group_start_en, .o_switch_busy);
`default_nettype wire
